// [common/bjs_pkg.sv]
// shared constants and types for the program-flow unit
package bjs_pkg;
	// operation selected by the instruction decoder upstream
	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_RELATIVE_JUMP = 5'h01,
		OP_POINTER_JUMP = 5'h02,
		OP_EXT_POINTER_JUMP = 5'h03,
		OP_DIRECT_JUMP = 5'h04,
		OP_RELATIVE_INVOKE = 5'h05,
		OP_POINTER_INVOKE = 5'h06,
		OP_EXT_POINTER_INVOKE = 5'h07,
		OP_DIRECT_INVOKE = 5'h08,
		OP_SUB_RETURN = 5'h09,
		OP_INTERRUPT_EXIT = 5'h0A,
		OP_COMPARE_SKIP_EQUAL = 5'h0B,
		OP_COMPARE = 5'h0C,
		OP_COMPARE_CARRY = 5'h0D,
		OP_COMPARE_IMM = 5'h0E,
		OP_SKIP_REG_BIT_CLEAR = 5'h0F,
		OP_SKIP_REG_BIT_ONE = 5'h10,
		OP_SKIP_IO_BIT_CLEAR = 5'h11,
		OP_SKIP_IO_BIT_ONE = 5'h12,
		OP_BRANCH_FLAG_ONE = 5'h13,
		OP_BRANCH_FLAG_ZERO = 5'h14,
		OP_BRANCH_SIGNED_NOT_LESS = 5'h15,
		OP_BRANCH_SIGNED_LESS = 5'h16
	} bjs_op_t;

	// sequencer states, gray coded
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HOLD = 2'b01
	} bjs_state_t;

	// status flag register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// instruction cycle counts
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_JUMP = 3'h2;
	localparam logic [2:0] CYC_DIRECT_JUMP = 3'h3;
	localparam logic [2:0] CYC_INVOKE = 3'h4;
	localparam logic [2:0] CYC_DIRECT_INVOKE = 3'h5;
	localparam logic [2:0] CYC_RETURN = 3'h5;
	localparam logic [2:0] CYC_TAKEN = 3'h2;
	localparam logic [2:0] CYC_SKIP_ONE_WORD = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO_WORD = 3'h3;

	// program counter steps
	localparam int STEP_NEXT = 1;
	localparam int STEP_SKIP_ONE = 2;
	localparam int STEP_SKIP_TWO = 3;
	localparam int POINTER_W = 16;
	localparam int BYTE_MSB = 7;
	localparam int NIBBLE_MSB = 3;
endpackage

// [design/bjs_branch_jump_skip_unit.sv]
// program-flow unit: jumps, invokes, returns, compares, skips and flag branches
`timescale 1ns/100ps
// What this block does
// - pointer jump loads PC from Z, 2 cycles
// - extended pointer jump uses segment:Z, 2 cycles
// - pointer invoke pushes return, jumps Z, 4 cycles
// - extended invoke pushes return, jumps segment:Z, 4 cycles
// - relative jump/invoke target PC+k+1, 2/4 cycles
// - compare-skip-equal skips when registers equal
// - compares only update Z N V C H S
// - register bit skip on clear or set
// - I/O bit skip on clear or set
// - flag branch on selected flag one/zero
// - equal branches test zero flag
// - carry branches test carry flag
// - minus/plus branches test negative flag
// - signed branches test N xor V
// - half-carry branches test H flag
// - T flag branches test T flag
module bjs_branch_jump_skip_unit #(
	parameter int PC_W = 22,
	parameter int OFFSET_W = 12
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic instrValid,
	input wire bjs_pkg::bjs_op_t instrOp,
	input wire logic [OFFSET_W-1:0] relOffset,
	input wire logic [PC_W-1:0] absTarget,
	input wire logic [2:0] flagSel,
	input wire logic [2:0] bitSel,
	input wire logic [7:0] operandA,
	input wire logic [7:0] operandB,
	input wire logic ioBitValue,
	input wire logic nextTwoWord,
	input wire logic [15:0] zPointer,
	input wire logic [PC_W-17:0] extendedJumpSegment,
	input wire logic [PC_W-1:0] stackPc,
	input wire logic statusWrite,
	input wire logic [7:0] statusWrData,
	output logic instrReady,
	output logic [PC_W-1:0] pc_reg,
	output logic [7:0] statusFlagRegister_reg,
	output logic pushReq_reg,
	output logic [PC_W-1:0] pushData_reg,
	output logic popReq_reg,
	output logic done_reg,
	output logic [2:0] cycleCount_reg
);
	bjs_pkg::bjs_state_t state_reg;
	bjs_pkg::bjs_state_t state_next;
	logic [2:0] remain_reg;
	logic accept;
	logic [PC_W-1:0] relTarget;
	logic [PC_W-1:0] segTarget;
	logic [PC_W-1:0] zTarget;
	logic [PC_W-1:0] pcPlusOne;
	logic [PC_W-1:0] skipTarget;
	logic [PC_W-1:0] pcTarget;
	logic [2:0] cycles;
	logic skipCond;
	logic branchCond;
	logic isBranch;
	logic isSkip;
	logic isInvoke;
	logic isCompare;
	logic [7:0] subB;
	logic [8:0] diff;
	logic [7:0] res;
	logic flagN;
	logic flagV;
	logic flagC;
	logic flagH;
	logic flagZ;
	logic [7:0] st;

	assign st = statusFlagRegister_reg;
	// new work is only taken while nothing multi-cycle is in flight
	assign instrReady = (state_reg == bjs_pkg::ST_IDLE);
	assign accept = instrValid && instrReady;

	// candidate targets; offset is sign extended to the counter width
	assign pcPlusOne = pc_reg + PC_W'(bjs_pkg::STEP_NEXT);
	assign relTarget = pcPlusOne + {{(PC_W-OFFSET_W){relOffset[OFFSET_W-1]}}, relOffset};
	assign zTarget = {{(PC_W-bjs_pkg::POINTER_W){1'b0}}, zPointer};
	assign segTarget = {extendedJumpSegment, zPointer};
	assign skipTarget = nextTwoWord ? pc_reg + PC_W'(bjs_pkg::STEP_SKIP_TWO)
		: pc_reg + PC_W'(bjs_pkg::STEP_SKIP_ONE);

	// compare datapath; carry-in only for the carry variant
	assign subB = operandB;
	assign diff = {1'b0, operandA} - {1'b0, subB}
		- {8'h00, (instrOp == bjs_pkg::OP_COMPARE_CARRY) & st[bjs_pkg::FLAG_C]};
	assign res = diff[7:0];
	assign flagN = res[bjs_pkg::BYTE_MSB];
	assign flagC = (~operandA[bjs_pkg::BYTE_MSB] & subB[bjs_pkg::BYTE_MSB])
		| (subB[bjs_pkg::BYTE_MSB] & res[bjs_pkg::BYTE_MSB])
		| (res[bjs_pkg::BYTE_MSB] & ~operandA[bjs_pkg::BYTE_MSB]);
	assign flagH = (~operandA[bjs_pkg::NIBBLE_MSB] & subB[bjs_pkg::NIBBLE_MSB])
		| (subB[bjs_pkg::NIBBLE_MSB] & res[bjs_pkg::NIBBLE_MSB])
		| (res[bjs_pkg::NIBBLE_MSB] & ~operandA[bjs_pkg::NIBBLE_MSB]);
	assign flagV = (operandA[bjs_pkg::BYTE_MSB] & ~subB[bjs_pkg::BYTE_MSB] & ~flagN)
		| (~operandA[bjs_pkg::BYTE_MSB] & subB[bjs_pkg::BYTE_MSB] & flagN);
	// with carry, a zero result keeps the previous Z so multi-byte compares chain
	assign flagZ = (instrOp == bjs_pkg::OP_COMPARE_CARRY)
		? ((res == 8'h00) & st[bjs_pkg::FLAG_Z]) : (res == 8'h00);

	// condition evaluation for skips and branches
	always_comb begin
		skipCond = 1'b0;
		branchCond = 1'b0;
		isBranch = 1'b0;
		isSkip = 1'b0;
		unique case (instrOp)
			bjs_pkg::OP_COMPARE_SKIP_EQUAL: begin
				isSkip = 1'b1;
				skipCond = (operandA == operandB);
			end
			bjs_pkg::OP_SKIP_REG_BIT_CLEAR: begin
				isSkip = 1'b1;
				skipCond = ~operandA[bitSel];
			end
			bjs_pkg::OP_SKIP_REG_BIT_ONE: begin
				isSkip = 1'b1;
				skipCond = operandA[bitSel];
			end
			bjs_pkg::OP_SKIP_IO_BIT_CLEAR: begin
				isSkip = 1'b1;
				skipCond = ~ioBitValue;
			end
			bjs_pkg::OP_SKIP_IO_BIT_ONE: begin
				isSkip = 1'b1;
				skipCond = ioBitValue;
			end
			// flagSel picks Z for equal, C for carry/lower, N for minus/plus,
			// H for half carry, T for transfer bit
			bjs_pkg::OP_BRANCH_FLAG_ONE: begin
				isBranch = 1'b1;
				branchCond = st[flagSel];
			end
			bjs_pkg::OP_BRANCH_FLAG_ZERO: begin
				isBranch = 1'b1;
				branchCond = ~st[flagSel];
			end
			bjs_pkg::OP_BRANCH_SIGNED_NOT_LESS: begin
				isBranch = 1'b1;
				branchCond = ~(st[bjs_pkg::FLAG_N] ^ st[bjs_pkg::FLAG_V]);
			end
			bjs_pkg::OP_BRANCH_SIGNED_LESS: begin
				isBranch = 1'b1;
				branchCond = st[bjs_pkg::FLAG_N] ^ st[bjs_pkg::FLAG_V];
			end
			default: begin
				isBranch = 1'b0;
			end
		endcase
	end

	assign isInvoke = (instrOp == bjs_pkg::OP_RELATIVE_INVOKE)
		|| (instrOp == bjs_pkg::OP_POINTER_INVOKE)
		|| (instrOp == bjs_pkg::OP_EXT_POINTER_INVOKE)
		|| (instrOp == bjs_pkg::OP_DIRECT_INVOKE);
	assign isCompare = (instrOp == bjs_pkg::OP_COMPARE)
		|| (instrOp == bjs_pkg::OP_COMPARE_CARRY)
		|| (instrOp == bjs_pkg::OP_COMPARE_IMM);

	// next counter value and cycle cost of the offered instruction
	always_comb begin
		pcTarget = pcPlusOne;
		cycles = bjs_pkg::CYC_ONE;
		unique case (instrOp)
			bjs_pkg::OP_RELATIVE_JUMP: begin
				pcTarget = relTarget;
				cycles = bjs_pkg::CYC_JUMP;
			end
			bjs_pkg::OP_POINTER_JUMP: begin
				pcTarget = zTarget;
				cycles = bjs_pkg::CYC_JUMP;
			end
			bjs_pkg::OP_EXT_POINTER_JUMP: begin
				pcTarget = segTarget;
				cycles = bjs_pkg::CYC_JUMP;
			end
			bjs_pkg::OP_DIRECT_JUMP: begin
				pcTarget = absTarget;
				cycles = bjs_pkg::CYC_DIRECT_JUMP;
			end
			bjs_pkg::OP_RELATIVE_INVOKE: begin
				pcTarget = relTarget;
				cycles = bjs_pkg::CYC_INVOKE;
			end
			bjs_pkg::OP_POINTER_INVOKE: begin
				pcTarget = zTarget;
				cycles = bjs_pkg::CYC_INVOKE;
			end
			bjs_pkg::OP_EXT_POINTER_INVOKE: begin
				pcTarget = segTarget;
				cycles = bjs_pkg::CYC_INVOKE;
			end
			bjs_pkg::OP_DIRECT_INVOKE: begin
				pcTarget = absTarget;
				cycles = bjs_pkg::CYC_DIRECT_INVOKE;
			end
			bjs_pkg::OP_SUB_RETURN, bjs_pkg::OP_INTERRUPT_EXIT: begin
				pcTarget = stackPc;
				cycles = bjs_pkg::CYC_RETURN;
			end
			default: begin
				if (isBranch && branchCond) begin
					pcTarget = relTarget;
					cycles = bjs_pkg::CYC_TAKEN;
				end else if (isSkip && skipCond) begin
					pcTarget = skipTarget;
					cycles = nextTwoWord ? bjs_pkg::CYC_SKIP_TWO_WORD
						: bjs_pkg::CYC_SKIP_ONE_WORD;
				end
			end
		endcase
	end

	// sequencer: holds off new work until the instruction's cycles have run
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			bjs_pkg::ST_IDLE: begin
				if (accept && cycles != bjs_pkg::CYC_ONE) begin
					state_next = bjs_pkg::ST_HOLD;
				end
			end
			bjs_pkg::ST_HOLD: begin
				if (remain_reg == bjs_pkg::CYC_ONE) begin
					state_next = bjs_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = bjs_pkg::ST_IDLE;
			end
		endcase
	end

	// state and remaining-cycle counter
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= bjs_pkg::ST_IDLE;
			remain_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				remain_reg <= cycles - bjs_pkg::CYC_ONE;
			end else if (remain_reg != 3'h0) begin
				remain_reg <= remain_reg - bjs_pkg::CYC_ONE;
			end
		end
	end

	// completion pulse on the last cycle of every instruction
	always_ff @(posedge clock) begin
		if (!nrst) begin
			done_reg <= 1'b0;
			cycleCount_reg <= 3'h0;
		end else begin
			done_reg <= (accept && cycles == bjs_pkg::CYC_ONE)
				|| (state_reg == bjs_pkg::ST_HOLD && remain_reg == bjs_pkg::CYC_ONE);
			if (accept) begin
				cycleCount_reg <= cycles;
			end
		end
	end

	// program counter moves at acceptance; the hold only stalls the next fetch
	always_ff @(posedge clock) begin
		if (!nrst) begin
			pc_reg <= '0;
		end else if (accept && instrOp != bjs_pkg::OP_NONE) begin
			pc_reg <= pcTarget;
		end
	end

	// stack traffic: one push for invokes, one pop for returns
	always_ff @(posedge clock) begin
		if (!nrst) begin
			pushReq_reg <= 1'b0;
			pushData_reg <= '0;
			popReq_reg <= 1'b0;
		end else begin
			pushReq_reg <= accept && isInvoke;
			popReq_reg <= accept && (instrOp == bjs_pkg::OP_SUB_RETURN
				|| instrOp == bjs_pkg::OP_INTERRUPT_EXIT);
			if (accept && isInvoke) begin
				// direct invoke is two words long, so its return skips the address word
				pushData_reg <= (instrOp == bjs_pkg::OP_DIRECT_INVOKE)
					? pc_reg + PC_W'(bjs_pkg::STEP_SKIP_ONE) : pcPlusOne;
			end
		end
	end

	// status flags: compares write six flags (Z N V C H S), interrupt exit sets I;
	// own updates win over an external write in the same cycle
	always_ff @(posedge clock) begin
		if (!nrst) begin
			statusFlagRegister_reg <= bjs_pkg::STATUS_RESET;
		end else if (accept && isCompare) begin
			statusFlagRegister_reg[bjs_pkg::FLAG_Z] <= flagZ;
			statusFlagRegister_reg[bjs_pkg::FLAG_N] <= flagN;
			statusFlagRegister_reg[bjs_pkg::FLAG_V] <= flagV;
			statusFlagRegister_reg[bjs_pkg::FLAG_C] <= flagC;
			statusFlagRegister_reg[bjs_pkg::FLAG_H] <= flagH;
			statusFlagRegister_reg[bjs_pkg::FLAG_S] <= flagN ^ flagV;
		end else if (accept && instrOp == bjs_pkg::OP_INTERRUPT_EXIT) begin
			statusFlagRegister_reg[bjs_pkg::FLAG_I] <= 1'b1;
		end else if (statusWrite) begin
			statusFlagRegister_reg <= statusWrData;
		end
	end
endmodule

// [verification/bjs_stack_model.sv]
// return-address stack on the far side of the push and pop pulses
`timescale 1ns/100ps
module bjs_stack_model #(
	parameter int PC_W = 22
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic pushReq,
	input wire logic [PC_W-1:0] pushData,
	input wire logic popReq,
	output logic [PC_W-1:0] stackPc
);
	logic [PC_W-1:0] mem [16];
	logic [3:0] sp;
	// empty stack shows an inverted word, never a stale return address
	assign stackPc = (sp != 4'h0) ? mem[sp - 4'h1] : ~mem[0];
	// push wins over pop; the unit never asks both at once
	always @(posedge clock) begin
		if (!nrst) begin
			sp <= 4'h0;
		end else if (pushReq) begin
			mem[sp] <= pushData;
			sp <= sp + 4'h1;
		end else if (popReq) begin
			sp <= sp - 4'h1;
		end
	end
endmodule

// [verification/bjs_unit_checker.sv]
// concurrent checks on the ports of the program-flow unit
`timescale 1ns/100ps
module bjs_unit_checker #(
	parameter int PC_W = 22
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic instrValid,
	input wire bjs_pkg::bjs_op_t instrOp,
	input wire logic [2:0] flagSel,
	input wire logic [15:0] zPointer,
	input wire logic [PC_W-17:0] extendedJumpSegment,
	input wire logic [PC_W-1:0] stackPc,
	input wire logic statusWrite,
	input wire logic instrReady,
	input wire logic [PC_W-1:0] pc_reg,
	input wire logic [7:0] statusFlagRegister_reg,
	input wire logic pushReq_reg,
	input wire logic popReq_reg,
	input wire logic done_reg,
	input wire logic [2:0] cycleCount_reg
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic acc;
	logic takenLat;
	assign acc = instrValid && instrReady;
	// branch decision kept from the accept edge, since flags may move later
	always_ff @(posedge clock) begin
		takenLat <= statusFlagRegister_reg[flagSel] == (instrOp == bjs_pkg::OP_BRANCH_FLAG_ONE);
	end
	sequence s_push_then_end;
		pushReq_reg ##1 !pushReq_reg ##2 done_reg;
	endsequence
	sequence s_pop_then_end;
		popReq_reg && pc_reg == $past(stackPc) ##4 done_reg;
	endsequence
	a_pointer_jump_target: assert property (acc && instrOp == bjs_pkg::OP_POINTER_JUMP
		|=> pc_reg == PC_W'($past(zPointer))) else $error("pointer jump target wrong");
	a_ext_jump_target: assert property (acc && instrOp == bjs_pkg::OP_EXT_POINTER_JUMP
		|=> pc_reg == {$past(extendedJumpSegment), $past(zPointer)})
		else $error("extended jump target wrong");
	a_jump_two_cycles: assert property (acc && instrOp inside {bjs_pkg::OP_RELATIVE_JUMP,
		bjs_pkg::OP_POINTER_JUMP, bjs_pkg::OP_EXT_POINTER_JUMP}
		|=> cycleCount_reg == 3'h2 && !done_reg ##1 done_reg) else $error("jump length wrong");
	a_invoke_four_cycles: assert property (acc && instrOp inside {bjs_pkg::OP_POINTER_INVOKE,
		bjs_pkg::OP_EXT_POINTER_INVOKE, bjs_pkg::OP_RELATIVE_INVOKE}
		|=> s_push_then_end) else $error("invoke sequence wrong");
	a_return_five_cycles: assert property (acc && instrOp inside {bjs_pkg::OP_SUB_RETURN,
		bjs_pkg::OP_INTERRUPT_EXIT} |=> s_pop_then_end) else $error("return sequence wrong");
	a_exit_sets_enable: assert property (acc && instrOp == bjs_pkg::OP_INTERRUPT_EXIT
		|=> statusFlagRegister_reg[bjs_pkg::FLAG_I]) else $error("exit left I clear");
	a_flags_kept: assert property (acc && !statusWrite && !(instrOp inside
		{bjs_pkg::OP_COMPARE, bjs_pkg::OP_COMPARE_CARRY, bjs_pkg::OP_COMPARE_IMM,
		bjs_pkg::OP_INTERRUPT_EXIT}) |=> $stable(statusFlagRegister_reg))
		else $error("flags changed by flow op");
	a_busy_refuses: assert property (acc |=> instrReady == (cycleCount_reg == 3'h1))
		else $error("ready wrong after accept");
	a_branch_cycle_count: assert property (acc && instrOp inside
		{bjs_pkg::OP_BRANCH_FLAG_ONE, bjs_pkg::OP_BRANCH_FLAG_ZERO}
		|=> cycleCount_reg == (takenLat ? 3'h2 : 3'h1)) else $error("branch count wrong");
endmodule
bind bjs_branch_jump_skip_unit bjs_unit_checker #(.PC_W(PC_W)) bjs_unit_checker_i (.*);

// [verification/tb_top.sv]
// random and corner-case bench for the program-flow unit
`timescale 1ns/100ps
module tb_top;
	localparam int PW = 22;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic instrValid = 1'b0;
	bjs_pkg::bjs_op_t instrOp = bjs_pkg::OP_NONE;
	logic [11:0] relOffset = 12'h000;
	logic [PW-1:0] absTarget = 22'h000000;
	logic [2:0] flagSel = 3'h0;
	logic [2:0] bitSel = 3'h0;
	logic [7:0] operandA = 8'h00;
	logic [7:0] operandB = 8'h00;
	logic ioBitValue = 1'b0;
	logic nextTwoWord = 1'b0;
	logic [15:0] zPointer = 16'h0000;
	logic [5:0] extendedJumpSegment = 6'h00;
	logic statusWrite = 1'b0;
	logic [7:0] statusWrData = 8'h00;
	logic instrReady, pushReq_reg, popReq_reg, done_reg;
	logic [PW-1:0] pc_reg, pushData_reg, stackPc, ePc, eNext;
	logic [7:0] statusFlagRegister_reg, eSr;
	logic [2:0] cycleCount_reg, eCyc;
	logic [31:0] seed = 32'h0001029F;
	logic [PW-1:0] stk[$];
	int failures = 0;
	int checks = 0;
	bjs_branch_jump_skip_unit #(.PC_W(PW), .OFFSET_W(12)) bjs_branch_jump_skip_unit_i (.*);
	bjs_stack_model #(.PC_W(PW)) bjs_stack_model_i (.clock, .nrst, .pushReq(pushReq_reg),
		.pushData(pushData_reg), .popReq(popReq_reg), .stackPc);
	// 40 MHz core clock
	always #12.5 clock = ~clock;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic cmpPc(input logic [PW-1:0] e, input logic [PW-1:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cmpSmall(input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// expected target, length and flags from the inputs about to be offered
	function automatic void predict();
		logic [7:0] res, bw;
		logic [PW-1:0] rel;
		logic hit, take;
		res = operandA - operandB;
		if (instrOp == bjs_pkg::OP_COMPARE_CARRY) res = res - {7'h00, eSr[bjs_pkg::FLAG_C]};
		bw = (~operandA & operandB) | (operandB & res) | (res & ~operandA);
		rel = ePc + PW'($signed(relOffset)) + 22'h000001;
		{hit, take, eCyc, eNext} = {2'b00, 3'h1, ePc + 22'h000001};
		case (instrOp)
			bjs_pkg::OP_NONE: eNext = ePc;
			bjs_pkg::OP_RELATIVE_JUMP: {eNext, eCyc} = {rel, 3'h2};
			bjs_pkg::OP_POINTER_JUMP: {eNext, eCyc} = {6'h00, zPointer, 3'h2};
			bjs_pkg::OP_EXT_POINTER_JUMP: {eNext, eCyc} = {extendedJumpSegment, zPointer, 3'h2};
			bjs_pkg::OP_DIRECT_JUMP: {eNext, eCyc} = {absTarget, 3'h3};
			bjs_pkg::OP_RELATIVE_INVOKE: {eNext, eCyc} = {rel, 3'h4};
			bjs_pkg::OP_POINTER_INVOKE: {eNext, eCyc} = {6'h00, zPointer, 3'h4};
			bjs_pkg::OP_EXT_POINTER_INVOKE: {eNext, eCyc} = {extendedJumpSegment, zPointer, 3'h4};
			bjs_pkg::OP_DIRECT_INVOKE: {eNext, eCyc} = {absTarget, 3'h5};
			bjs_pkg::OP_SUB_RETURN, bjs_pkg::OP_INTERRUPT_EXIT: {eNext, eCyc} = {stk[$], 3'h5};
			bjs_pkg::OP_COMPARE_SKIP_EQUAL: hit = operandA == operandB;
			bjs_pkg::OP_SKIP_REG_BIT_CLEAR: hit = !operandA[bitSel];
			bjs_pkg::OP_SKIP_REG_BIT_ONE: hit = operandA[bitSel];
			bjs_pkg::OP_SKIP_IO_BIT_CLEAR: hit = !ioBitValue;
			bjs_pkg::OP_SKIP_IO_BIT_ONE: hit = ioBitValue;
			bjs_pkg::OP_BRANCH_FLAG_ONE: take = eSr[flagSel];
			bjs_pkg::OP_BRANCH_FLAG_ZERO: take = !eSr[flagSel];
			bjs_pkg::OP_BRANCH_SIGNED_NOT_LESS: take = !(eSr[bjs_pkg::FLAG_N] ^ eSr[bjs_pkg::FLAG_V]);
			bjs_pkg::OP_BRANCH_SIGNED_LESS: take = eSr[bjs_pkg::FLAG_N] ^ eSr[bjs_pkg::FLAG_V];
			default: ;
		endcase
		if (hit) {eNext, eCyc} = nextTwoWord ? {ePc + 22'h000003, 3'h3} : {ePc + 22'h000002, 3'h2};
		if (take) {eNext, eCyc} = {rel, 3'h2};
		if (instrOp == bjs_pkg::OP_INTERRUPT_EXIT) eSr[bjs_pkg::FLAG_I] = 1'b1;
		if (instrOp inside {bjs_pkg::OP_COMPARE, bjs_pkg::OP_COMPARE_CARRY,
			bjs_pkg::OP_COMPARE_IMM}) begin
			eSr[bjs_pkg::FLAG_Z] = res == 8'h00 && (instrOp != bjs_pkg::OP_COMPARE_CARRY || eSr[1]);
			eSr[bjs_pkg::FLAG_C] = bw[7];
			eSr[bjs_pkg::FLAG_H] = bw[3];
			eSr[bjs_pkg::FLAG_N] = res[7];
			eSr[bjs_pkg::FLAG_V] = (operandA[7] & ~operandB[7] & ~res[7])
				| (~operandA[7] & operandB[7] & res[7]);
			eSr[bjs_pkg::FLAG_S] = res[7] ^ eSr[bjs_pkg::FLAG_V];
		end
	endfunction
	// offer one instruction, then poke at the unit with ignored offers while it is busy
	task automatic run();
		logic [31:0] r;
		predict();
		instrValid = 1'b1;
		@(negedge clock);
		cmpPc(eNext, pc_reg);
		cmpSmall(eSr, statusFlagRegister_reg);
		cmpSmall({5'h00, eCyc}, {5'h00, cycleCount_reg});
		if (instrOp inside {bjs_pkg::OP_RELATIVE_INVOKE, bjs_pkg::OP_POINTER_INVOKE,
			bjs_pkg::OP_EXT_POINTER_INVOKE, bjs_pkg::OP_DIRECT_INVOKE}) begin
			stk.push_back(ePc + ((instrOp == bjs_pkg::OP_DIRECT_INVOKE) ? 22'h000002 : 22'h000001));
			cmpPc(stk[$], pushData_reg);
		end
		if (instrOp inside {bjs_pkg::OP_SUB_RETURN, bjs_pkg::OP_INTERRUPT_EXIT}) void'(stk.pop_back());
		for (int i = 1; i < eCyc; i++) begin
			r = rnd();
			instrValid = r[0];
			instrOp = bjs_pkg::bjs_op_t'(r[12:8] % 5'd23);
			@(negedge clock);
		end
		cmpSmall(8'h01, {7'h00, done_reg});
		cmpPc(eNext, pc_reg);
		ePc = eNext;
	endtask
	initial begin
		logic [31:0] r;
		repeat (8) @(negedge clock);
		nrst = 1'b1;
		{ePc, eSr} = {22'h000000, 8'h00};
		for (int it = 0; it < 300; it++) begin
			r = rnd();
			if (it == 150) begin
				instrValid = 1'b0;
				nrst = 1'b0;
				@(negedge clock);
				nrst = 1'b1;
				{ePc, eSr} = {22'h000000, 8'h00};
				stk.delete();
				cmpPc(ePc, pc_reg);
			end
			if (r[0]) begin
				instrValid = 1'b0;
				statusWrite = 1'b1;
				statusWrData = r[31:24];
				eSr = r[31:24];
				@(negedge clock);
				statusWrite = 1'b0;
			end
			instrOp = bjs_pkg::bjs_op_t'(r[5:1] % 5'd23);
			{relOffset, flagSel, bitSel, ioBitValue, nextTwoWord} = {r[23:12], r[11:6], r[7:6]};
			if (it % 40 == 3) relOffset = (it % 80 == 3) ? 12'h800 : 12'h7FF;
			r = rnd();
			operandA = r[7:0];
			operandB = r[8] ? r[7:0] : r[16:9];
			{zPointer, extendedJumpSegment, absTarget} = {r[31:10], r[21:0]};
			if ((stk.size() == 0
				&& instrOp inside {bjs_pkg::OP_SUB_RETURN, bjs_pkg::OP_INTERRUPT_EXIT})
				|| (stk.size() > 14
				&& instrOp inside {[bjs_pkg::OP_RELATIVE_INVOKE:bjs_pkg::OP_DIRECT_INVOKE]}))
				instrOp = bjs_pkg::OP_NONE;
			run();
		end
		instrValid = 1'b0;
		summarize();
	end
	// hang guard, far beyond the fewer than two thousand cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		summarize();
	end
endmodule
